// file: dout_func_pkg.sv
// Package with constants and types for the digital output function selector
package dout_func_pkg;

	// ==========================================================
	// Parameter addresses on the fieldbus
	localparam logic [15:0] ADDR_OUTPUT_TWO_FUNC = 16'h0716;
	localparam logic [15:0] ADDR_OUTPUT_THREE_FUNC = 16'h0718;

	// ==========================================================
	// Selector layout and factory value
	localparam int CODE_W = 16;
	localparam int NUM_OUTPUTS = 2;
	localparam logic [15:0] CODE_FACTORY = 16'h0001;

	// ==========================================================
	// Selector codes
	typedef enum logic [15:0] {
		FUNC_FREELY_AVAILABLE = 16'h0001,
		FUNC_NO_FAULT = 16'h0002,
		FUNC_OPERATION_ENABLED = 16'h0003,
		FUNC_IN_POS_WINDOW = 16'h0005,
		FUNC_IN_VEL_WINDOW = 16'h0006,
		FUNC_VELOCITY_LOW = 16'h0007,
		FUNC_CURRENT_LOW = 16'h0008,
		FUNC_HALT_ACK = 16'h0009,
		FUNC_STANDSTILL = 16'h000d,
		FUNC_SELECTED_ERROR = 16'h000e,
		FUNC_SELECTED_WARNING = 16'h0010
	} func_code_t;

	// ==========================================================
	// Power-up load sequencer
	typedef enum logic [1:0] {
		ST_LOAD_REQ = 2'b00,
		ST_LOAD_TAKE = 2'b01,
		ST_RUN = 2'b10
	} seq_state_t;

	function automatic logic code_is_valid(input logic [15:0] code);
		case (code)
			FUNC_FREELY_AVAILABLE, FUNC_NO_FAULT, FUNC_OPERATION_ENABLED,
			FUNC_IN_POS_WINDOW, FUNC_IN_VEL_WINDOW, FUNC_VELOCITY_LOW,
			FUNC_CURRENT_LOW, FUNC_HALT_ACK, FUNC_STANDSTILL,
			FUNC_SELECTED_ERROR, FUNC_SELECTED_WARNING: code_is_valid = 1'b1;
			default: code_is_valid = 1'b0;
		endcase
	endfunction : code_is_valid

endpackage : dout_func_pkg

// file: code_store_if.sv
// Interface between the selector logic and the persistent code store
`timescale 1ns/1ps
`default_nettype none
interface code_store_if #(
	parameter int DEPTH = 2,
	parameter int WIDTH = 16
);
	logic we;
	logic [$clog2(DEPTH)-1:0] waddr;
	logic [WIDTH-1:0] wdata;
	logic [$clog2(DEPTH)-1:0] raddr;
	logic [WIDTH-1:0] rdata;

	modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
	modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : code_store_if
`default_nettype wire

// file: code_store.sv
// Persistent store of the output selector codes, registered read port
`timescale 1ns/1ps
`default_nettype none
module code_store #(
	parameter int DEPTH = 2,
	parameter int WIDTH = 16,
	parameter logic [15:0] INIT = 16'h0001
) (
	// Clock
	input wire logic i_clk,
	// Access port
	code_store_if.store port
);

	// ==========================================================
	// Storage
	// No reset: the contents model non-volatile memory that survives power-up
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [WIDTH-1:0] rdata_r;

	initial begin
		for (int i = 0; i < DEPTH; i++) begin
			mem_r[i] = WIDTH'(INIT);
		end
	end

	always_ff @(posedge i_clk) begin
		if (port.we) begin
			mem_r[port.waddr] <= port.wdata;
		end
	end

	always_ff @(posedge i_clk) begin
		rdata_r <= mem_r[port.raddr];
	end

	assign port.rdata = rdata_r;

endmodule : code_store
`default_nettype wire

// file: digital_output_function_select.sv
// Function selection for two digital outputs of a servo drive
// Operation
// - Code 1 leaves the output unbound, driven by the free-use level input.
// - Code 2 drives the output while in ready-to-switch-on, switched-on or operation-enabled.
// - Code 3 drives the output only while in operation-enabled.
// - Code 5 drives the output while the position deviation is inside its window.
// - Code 6 drives the output while the velocity deviation is inside its window.
// - Code 7 drives the output while the motor velocity is below its threshold.
// - Code 8 drives the output while the motor current is below its threshold.
// - Code 9 drives the output to acknowledge a completed halt.
// - Code 13 drives the output while the motor is at standstill.
// - Code 14 drives the output while any selected error is active.
// - Code 16 drives the output while any selected warning is active.
// - A selector write is accepted only while the power stage is disabled.
// - A written code takes effect only at the next power-up; until then the old one stays.
// - Each selector is a 16-bit read/write persistent value at addresses 1814 and 1816.
`timescale 1ns/1ps
`default_nettype none
module digital_output_function_select #(
	parameter int NUM_OUT = dout_func_pkg::NUM_OUTPUTS,
	parameter int CODE_W = dout_func_pkg::CODE_W
) (
	// Clock and power-on reset
	input wire logic i_clk,
	input wire logic i_srst,
	// Parameter access
	input wire logic [15:0] i_par_addr,
	input wire logic i_par_wr,
	input wire logic i_par_rd,
	input wire logic [15:0] i_par_wdata,
	output logic o_par_ready,
	output logic o_par_ack,
	output logic o_par_err,
	output logic [15:0] o_par_rdata,
	// Drive status conditions
	input wire logic i_power_stage_en,
	input wire logic i_state_ready_to_switch_on,
	input wire logic i_state_switched_on,
	input wire logic i_state_operation_enabled,
	input wire logic i_in_pos_window,
	input wire logic i_in_vel_window,
	input wire logic i_velocity_low,
	input wire logic i_current_low,
	input wire logic i_halt_ack,
	input wire logic i_standstill,
	input wire logic i_selected_error,
	input wire logic i_selected_warning,
	// Free-use levels for outputs set to code 1
	input wire logic [NUM_OUT-1:0] i_free_level,
	// Output pins, bit 0 is output two, bit 1 output three
	output logic [NUM_OUT-1:0] o_digital_output,
	output logic [NUM_OUT-1:0] o_function_active
);

	// ==========================================================
	// Store and sequencer
	code_store_if #(.DEPTH(NUM_OUT), .WIDTH(CODE_W)) store_port ();

	code_store #(
		.DEPTH(NUM_OUT),
		.WIDTH(CODE_W),
		.INIT(dout_func_pkg::CODE_FACTORY)
	) u_store (
		.i_clk(i_clk),
		.port(store_port.store)
	);

	localparam int IDX_W = $clog2(NUM_OUT);

	dout_func_pkg::seq_state_t state_r;
	logic [IDX_W-1:0] load_idx_r;
	logic [CODE_W-1:0] active_code_r [NUM_OUT];

	// Power-up copies every stored code into the active set once
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state_r <= dout_func_pkg::ST_LOAD_REQ;
			load_idx_r <= '0;
		end else begin
			case (state_r)
				dout_func_pkg::ST_LOAD_REQ: begin
					state_r <= dout_func_pkg::ST_LOAD_TAKE;
				end
				dout_func_pkg::ST_LOAD_TAKE: begin
					if (load_idx_r == IDX_W'(NUM_OUT - 1)) begin
						state_r <= dout_func_pkg::ST_RUN;
					end else begin
						load_idx_r <= load_idx_r + IDX_W'(1);
						state_r <= dout_func_pkg::ST_LOAD_REQ;
					end
				end
				default: begin
					state_r <= dout_func_pkg::ST_RUN;
				end
			endcase
		end
	end

	// Active codes change only at power-up, never on a write
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			for (int i = 0; i < NUM_OUT; i++) begin
				active_code_r[i] <= dout_func_pkg::CODE_FACTORY;
			end
		end else if (state_r == dout_func_pkg::ST_LOAD_TAKE) begin
			active_code_r[load_idx_r] <= store_port.rdata;
		end
	end

	// ==========================================================
	// Parameter access
	logic run;
	logic addr_hit;
	logic [IDX_W-1:0] addr_idx;
	logic wr_ok;
	logic rd_pend_r;

	assign run = (state_r == dout_func_pkg::ST_RUN);
	assign o_par_ready = run;

	always_comb begin
		addr_hit = 1'b0;
		addr_idx = '0;
		if (i_par_addr == dout_func_pkg::ADDR_OUTPUT_TWO_FUNC) begin
			addr_hit = 1'b1;
			addr_idx = IDX_W'(0);
		end else if (i_par_addr == dout_func_pkg::ADDR_OUTPUT_THREE_FUNC) begin
			addr_hit = 1'b1;
			addr_idx = IDX_W'(1);
		end
	end

	// A running power stage or an unlisted code refuses the write
	assign wr_ok = run && i_par_wr && addr_hit && !i_power_stage_en
		&& dout_func_pkg::code_is_valid(i_par_wdata);

	assign store_port.we = wr_ok;
	assign store_port.waddr = addr_idx;
	assign store_port.wdata = i_par_wdata;
	assign store_port.raddr = run ? addr_idx : load_idx_r;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_par_ack <= 1'b0;
			o_par_err <= 1'b0;
			rd_pend_r <= 1'b0;
		end else begin
			o_par_ack <= run && (i_par_wr || i_par_rd);
			o_par_err <= run && (i_par_wr || i_par_rd) && !(i_par_wr ? wr_ok : addr_hit);
			rd_pend_r <= run && i_par_rd && !i_par_wr && addr_hit;
		end
	end

	// Reads show the stored code, which may differ from the active one
	always_comb begin
		o_par_rdata = 16'h0000;
		if (rd_pend_r) begin
			o_par_rdata = store_port.rdata;
		end
	end

	// ==========================================================
	// Output function mux
	logic no_fault;

	assign no_fault = i_state_ready_to_switch_on || i_state_switched_on
		|| i_state_operation_enabled;

	for (genvar g = 0; g < NUM_OUT; g++) begin : g_out
		logic level;
		logic bound;

		always_comb begin
			level = 1'b0;
			bound = 1'b1;
			case (active_code_r[g])
				dout_func_pkg::FUNC_FREELY_AVAILABLE: begin
					level = i_free_level[g];
					bound = 1'b0;
				end
				dout_func_pkg::FUNC_NO_FAULT: level = no_fault;
				dout_func_pkg::FUNC_OPERATION_ENABLED: level = i_state_operation_enabled;
				dout_func_pkg::FUNC_IN_POS_WINDOW: level = i_in_pos_window;
				dout_func_pkg::FUNC_IN_VEL_WINDOW: level = i_in_vel_window;
				dout_func_pkg::FUNC_VELOCITY_LOW: level = i_velocity_low;
				dout_func_pkg::FUNC_CURRENT_LOW: level = i_current_low;
				dout_func_pkg::FUNC_HALT_ACK: level = i_halt_ack;
				dout_func_pkg::FUNC_STANDSTILL: level = i_standstill;
				dout_func_pkg::FUNC_SELECTED_ERROR: level = i_selected_error;
				dout_func_pkg::FUNC_SELECTED_WARNING: level = i_selected_warning;
				default: begin
					level = 1'b0;
					bound = 1'b0;
				end
			endcase
		end

		// One register stage, no debounce or filter
		always_ff @(posedge i_clk) begin
			if (i_srst) begin
				o_digital_output[g] <= 1'b0;
				o_function_active[g] <= 1'b0;
			end else begin
				o_digital_output[g] <= level;
				o_function_active[g] <= bound;
			end
		end
	end

endmodule : digital_output_function_select
`default_nettype wire

// file: dout_func_sva.sv
// Checker for the digital output function selector
`timescale 1ns/1ps
`default_nettype none
module dout_func_sva #(
	parameter int NUM_OUT = 2
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// Watched ports
	input wire logic [15:0] i_par_addr,
	input wire logic i_par_wr,
	input wire logic i_par_rd,
	input wire logic [15:0] i_par_wdata,
	input wire logic i_power_stage_en,
	input wire logic [NUM_OUT-1:0] i_free_level,
	input wire logic o_par_ready,
	input wire logic o_par_ack,
	input wire logic o_par_err,
	input wire logic [15:0] o_par_rdata,
	input wire logic [NUM_OUT-1:0] o_digital_output,
	input wire logic [NUM_OUT-1:0] o_function_active
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	logic req;
	logic mapped;
	assign req = o_par_ready && (i_par_wr || i_par_rd);
	assign mapped = i_par_addr == 16'h0716 || i_par_addr == 16'h0718;
	// ==========================
	// Properties
	property p_ack; req |=> o_par_ack; endproperty
	a_ack: assert property (p_ack) else $error("missing ack");
	property p_no_ack; !req |=> !o_par_ack; endproperty
	a_no_ack: assert property (p_no_ack) else $error("stray ack");
	property p_pwr; req && i_par_wr && i_power_stage_en |=> o_par_err; endproperty
	a_pwr: assert property (p_pwr) else $error("write taken while powered");
	property p_bad;
		req && i_par_wr && (i_par_wdata == 16'h0004 || i_par_wdata > 16'h0010) |=> o_par_err;
	endproperty
	a_bad: assert property (p_bad) else $error("bad code taken");
	property p_rd_err;
		req && !i_par_wr && !mapped |=> o_par_err && o_par_rdata == 16'h0000;
	endproperty
	a_rd_err: assert property (p_rd_err) else $error("unmapped read");
	property p_wr_ok;
		req && i_par_wr && !i_power_stage_en && mapped && i_par_wdata == 16'h0003
			|=> o_par_ack && !o_par_err;
	endproperty
	a_wr_ok: assert property (p_wr_ok) else $error("good write refused");
	// Settle two cycles after the load so the active codes have landed
	property p_free;
		o_par_ready && $past(o_par_ready, 2) && !o_function_active[0]
			|-> o_digital_output[0] == $past(i_free_level[0]);
	endproperty
	a_free: assert property (p_free) else $error("free level not copied");
	property p_stable; o_par_ready && $past(o_par_ready, 2) |-> $stable(o_function_active); endproperty
	a_stable: assert property (p_stable) else $error("function changed in run");
	c_wr: cover property (req && i_par_wr ##1 !o_par_err);
	c_refused: cover property (o_par_ack && o_par_err);
	c_bound: cover property (o_function_active == 2'b11);
endmodule : dout_func_sva
bind digital_output_function_select dout_func_sva #(.NUM_OUT(NUM_OUT)) dout_func_sva_i (
	.i_clk, .i_srst, .i_par_addr, .i_par_wr, .i_par_rd, .i_par_wdata, .i_power_stage_en,
	.i_free_level, .o_par_ready, .o_par_ack, .o_par_err, .o_par_rdata, .o_digital_output,
	.o_function_active);
`default_nettype wire

// file: machine_input_model.sv
// Model of the machine inputs wired to the two outputs
`timescale 1ns/1ps
`default_nettype none
module machine_input_model (
	input wire logic i_clk,
	input wire logic [1:0] i_level,
	output logic [1:0] o_seen
);
	// The machine latches the pins one clock late
	always_ff @(posedge i_clk) begin
		o_seen <= i_level;
	end
endmodule : machine_input_model
`default_nettype wire

// file: tb_top.sv
// Testbench for the digital output function selector
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic i_clk, i_srst, wr, rd, pwr, ready, ack, err;
	logic [15:0] addr, wdata, rdata, c2, c3, p2, p3;
	logic [10:0] cond;
	logic [1:0] free, dout, act, seen;
	logic [31:0] rng = 32'hbfceaa4e;
	logic [16:0] expq[$];
	int n_fail = 0;
	int n_compared = 0;
	logic [15:0] codes[11] = '{16'h0001, 16'h0002, 16'h0003, 16'h0005, 16'h0006, 16'h0007,
		16'h0008, 16'h0009, 16'h000d, 16'h000e, 16'h0010};
	digital_output_function_select digital_output_function_select_i (
		.i_clk(i_clk), .i_srst(i_srst), .i_par_addr(addr), .i_par_wr(wr), .i_par_rd(rd),
		.i_par_wdata(wdata), .o_par_ready(ready), .o_par_ack(ack), .o_par_err(err),
		.o_par_rdata(rdata), .i_power_stage_en(pwr), .i_state_ready_to_switch_on(cond[0]),
		.i_state_switched_on(cond[1]), .i_state_operation_enabled(cond[2]),
		.i_in_pos_window(cond[3]), .i_in_vel_window(cond[4]), .i_velocity_low(cond[5]),
		.i_current_low(cond[6]), .i_halt_ack(cond[7]), .i_standstill(cond[8]),
		.i_selected_error(cond[9]), .i_selected_warning(cond[10]), .i_free_level(free),
		.o_digital_output(dout), .o_function_active(act));
	machine_input_model machine_input_model_i (.i_clk(i_clk), .i_level(dout), .o_seen(seen));
	// ==========================
	// Helpers
	task automatic check(input string what, input logic [16:0] got, input logic [16:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic complete_run();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run
	function automatic logic fx(input logic [15:0] c, input logic f);
		case (c)
			16'h0001: return f;
			16'h0002: return |cond[2:0];
			16'h0003: return cond[2];
			16'h000d: return cond[8];
			16'h000e: return cond[9];
			16'h0010: return cond[10];
			default: return cond[c - 16'h0002];
		endcase
	endfunction : fx
	task automatic req(input logic w, input logic [15:0] a, d, input logic p, input logic [16:0] e);
		expq.push_back(e);
		{wr, rd, addr, wdata, pwr} = {w, !w, a, d, p};
		@(posedge i_clk) #2;
	endtask : req
	task automatic power_up(input int n);
		i_srst = 1'b1;
		repeat (n) @(posedge i_clk);
		#2 i_srst = 1'b0;
		for (int k = 0; k < 20 && ready !== 1'b1; k++) @(posedge i_clk) #2;
		if (ready !== 1'b1) begin
			n_fail++;
			complete_run();
		end
		repeat (2) @(posedge i_clk) #2;
	endtask : power_up
	task automatic pins(input logic [15:0] a2, a3);
		logic [1:0] prev;
		repeat (6) begin
			prev = dout;
			rng ^= rng << 13;
			rng ^= rng >> 17;
			rng ^= rng << 5;
			{cond, free, pwr, wr, rd} = {rng[13:0], 2'b00};
			@(posedge i_clk) #2;
			check("pins", {13'h0, act, dout}, {13'h0, a3 != 16'h0001, a2 != 16'h0001,
				fx(a3, free[1]), fx(a2, free[0])});
			check("machine", {15'h0, seen}, {15'h0, prev});
		end
	endtask : pins
	// ==========================
	// Stimulus and monitor
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	always @(negedge i_clk) begin
		if (ack === 1'b1)
			check("bus", {err, rdata}, expq.size() ? expq.pop_front() : 17'h1ffff);
	end
	initial begin
		{wr, rd, pwr, addr, wdata, cond, free} = '0;
		{p2, p3} = {16'h0001, 16'h0001};
		power_up(16);
		req(0, 16'h0718, 16'h0, 0, 17'h00001);
		for (int k = 0; k < 11; k++) begin
			c2 = codes[k];
			c3 = codes[(k + 5) % 11];
			req(1, 16'h0716, c2, 0, 17'h0);
			req(1, 16'h0718, c3, 0, 17'h0);
			req(0, 16'h0716, 16'h0, 0, {1'b0, c2});
			pins(p2, p3);
			power_up(2);
			pins(c2, c3);
			{p2, p3} = {c2, c3};
		end
		req(1, 16'h0716, 16'h0003, 1, 17'h10000);
		req(1, 16'h0716, 16'h0011, 0, 17'h10000);
		req(1, 16'h0718, 16'h0004, 0, 17'h10000);
		req(0, 16'h0720, 16'h0, 0, 17'h10000);
		req(0, 16'h0716, 16'h0, 0, {1'b0, c2});
		req(0, 16'h0718, 16'h0, 0, {1'b0, c3});
		{wr, rd} = 2'b00;
		repeat (3) @(posedge i_clk) #2;
		check("pending", 17'(expq.size()), 17'h0);
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
